// ### logic/packed_simd_fp_alias_state.sv
/*
 Aliased packed-integer / floating-point data register state with tag word,
 stack top field, fault gating, save/restore tag handling and an Avalon-MM
 slave for control flags and debug visibility.
 Assumes one core clock, instruction inputs synchronous to it, one
 instruction per cycle at most, and an Avalon master that holds requests.
*/
`timescale 1ns/1ps
`include "packed_simd_fp_alias_defs.svh"
module packed_simd_fp_alias_state (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   // avalon-mm slave
   input wire logic [`ADDR_W-1:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   // instruction stream
   input wire logic op_valid_i,
   input wire packed_simd_pkg::op_kind_t op_kind_i,
   input wire logic [2:0] op_reg_i,
   input wire logic [`FP_REG_W-1:0] op_data_i,
   input wire logic op_tag_empty_i,
   input wire logic [`STATUS_W-1:0] op_status_i,
   input wire logic op_status_we_i,
   input wire logic [`TAG_W-1:0] tag_img_in_i,
   input wire logic fp_err_pending_i,
   // results
   output logic op_done_o,
   output packed_simd_pkg::fault_t fault_o,
   output logic [`PACKED_W-1:0] packed_rdata_o,
   output logic [`TAG_W-1:0] tag_img_o,
   output logic tag_img_valid_o,
   output logic [`TAG_W-1:0] tag_word_o,
   output logic [`STATUS_W-1:0] status_word_o,
   output logic [2:0] stack_top_o
);
   import packed_simd_pkg::*;

   logic [`FP_REG_W-1:0] fp_reg_q [`NUM_FP_REGS];
   logic [`FP_REG_W-1:0] fp_reg_d [`NUM_FP_REGS];
   logic [`TAG_W-1:0] tag_q, tag_d;
   logic [`STATUS_W-1:0] status_q, status_d;
   logic [7:0] ctrl_q, ctrl_d;
   logic [2:0] regsel_q, regsel_d;
   logic ack_q, ack_d;
   logic [31:0] rdata_q, rdata_d;
   logic done_q, done_d;
   fault_t fault_q, fault_d;
   logic [`PACKED_W-1:0] prd_q, prd_d;
   logic [`TAG_W-1:0] img_q, img_d;
   logic img_valid_q, img_valid_d;

   logic emulate_flag, task_switched_flag, monitor_coproc_flag;
   logic is_packed, packed_exec, is_save, is_restore;
   logic [`TAG_W-1:0] class_tags;
   logic bus_req, bus_wr_take;
   // packed copies for the checks; sampled functions need plain vectors
   logic [`NUM_FP_REGS*`FP_REG_W-1:0] fp_flat;
   logic [`TAG_W-1:0] img_empty;

   // classify a register's contents: zero, special or nonzero
   function automatic logic [1:0] classify(input logic [`FP_REG_W-1:0] v);
      logic [14:0] e;
      logic [63:0] m;
      e = v[78:64];
      m = v[63:0];
      if (e == 15'h0000 && m == 64'h0) begin
         classify = `TAG_ZERO;
      end else if (e == `EXP_ALL_ONES || e == 15'h0000 || !m[63]) begin
         classify = `TAG_SPECIAL;
      end else begin
         classify = `TAG_VALID;
      end
   endfunction : classify

   assign emulate_flag = ctrl_q[`CTRL_EMULATE_BIT];
   assign task_switched_flag = ctrl_q[`CTRL_TASKSW_BIT];
   // only reported back to software; the block never gates on it
   assign monitor_coproc_flag = ctrl_q[`CTRL_MONITOR_BIT];

   assign is_packed = op_valid_i && (op_kind_i == OP_PACKED_READ ||
      op_kind_i == OP_PACKED_WRITE || op_kind_i == OP_CLEAR_PACKED);
   // gating never looks at the tag word
   assign packed_exec = is_packed && !emulate_flag && !task_switched_flag &&
      !fp_err_pending_i;
   assign is_save = op_valid_i && (op_kind_i == OP_FP_SAVE ||
      op_kind_i == OP_FP_ENV_STORE || op_kind_i == OP_EXT_SAVE);
   assign is_restore = op_valid_i && (op_kind_i == OP_FP_RESTORE ||
      op_kind_i == OP_FP_ENV_LOAD || op_kind_i == OP_EXT_RESTORE);

   // per-register tag from contents, field n at bits 2n+1..2n
   genvar gi;
   generate
      for (gi = 0; gi < `NUM_FP_REGS; gi++) begin : g_class
         assign class_tags[2*gi+1:2*gi] = (tag_q[2*gi+1:2*gi] == `TAG_EMPTY)
            ? `TAG_EMPTY : classify(fp_reg_q[gi]);
         assign fp_flat[gi*`FP_REG_W+:`FP_REG_W] = fp_reg_q[gi];
         // image fields that a restore has to keep empty
         assign img_empty[2*gi+:2] =
            {2{tag_img_in_i[2*gi+:2] == `TAG_EMPTY}};
      end
   endgenerate

   // fault priority: emulate, then task switch, then pending fp error
   always_comb begin
      done_d = op_valid_i;
      fault_d = FLT_NONE;
      if (is_packed) begin
         if (emulate_flag) begin
            fault_d = FLT_INVALID_OPCODE;
         end else if (task_switched_flag) begin
            fault_d = FLT_COPROC_UNAVAIL;
         end else if (fp_err_pending_i) begin
            fault_d = FLT_FP_ERROR;
         end
      end
   end

   // data registers: fixed physical index, stack top never used
   always_comb begin
      for (int i = 0; i < `NUM_FP_REGS; i++) begin
         fp_reg_d[i] = fp_reg_q[i];
      end
      prd_d = prd_q;
      if (packed_exec && op_kind_i == OP_PACKED_WRITE) begin
         fp_reg_d[op_reg_i] = {`UPPER_FILL, op_data_i[`PACKED_W-1:0]};
      end else if (op_valid_i && op_kind_i == OP_FP_WRITE) begin
         fp_reg_d[op_reg_i] = op_data_i;
      end
      if (packed_exec && op_kind_i == OP_PACKED_READ) begin
         prd_d = fp_reg_q[op_reg_i][`PACKED_W-1:0];
      end
   end

   // tag word and status word side effects
   always_comb begin
      tag_d = tag_q;
      status_d = status_q;
      img_d = img_q;
      img_valid_d = 1'b0;
      if (packed_exec) begin
         // only the stack top moves; other status bits are kept
         status_d[`TOP_MSB:`TOP_LSB] = 3'h0;
         if (op_kind_i == OP_CLEAR_PACKED) begin
            tag_d = `TAGS_ALL_EMPTY;
         end else begin
            tag_d = `TAGS_ALL_VALID;
         end
      end else if (op_valid_i && op_kind_i == OP_FP_WRITE) begin
         // only the written register's field changes
         tag_d[2*op_reg_i+:2] = op_tag_empty_i ? `TAG_EMPTY
            : `TAG_VALID;
         if (op_status_we_i) begin
            status_d = op_status_i;
         end
      end else if (is_save) begin
         img_d = class_tags;
         img_valid_d = 1'b1;
         tag_d = `TAGS_ALL_EMPTY;
      end else if (is_restore) begin
         // the memory image is only read, never written back
         for (int i = 0; i < `NUM_FP_REGS; i++) begin
            tag_d[2*i+:2] = (tag_img_in_i[2*i+:2] == `TAG_EMPTY)
               ? `TAG_EMPTY : classify(fp_reg_q[i]);
         end
      end
   end

   // avalon slave: one wait cycle, read data registered with the answer
   assign bus_req = avs_read_i || avs_write_i;
   assign bus_wr_take = avs_write_i && ack_q;
   always_comb begin
      ack_d = bus_req && !ack_q;
      rdata_d = rdata_q;
      ctrl_d = ctrl_q;
      regsel_d = regsel_q;
      if (avs_read_i && !ack_q) begin
         if (avs_address_i == `OFF_CTRL) begin
            rdata_d = {24'h0, ctrl_q};
         end else if (avs_address_i == `OFF_STATE) begin
            rdata_d = {status_q, tag_q};
         end else if (avs_address_i == `OFF_FAULT) begin
            rdata_d = {29'h0, monitor_coproc_flag, fault_q};
         end else if (avs_address_i == `OFF_REGSEL) begin
            rdata_d = {29'h0, regsel_q};
         end else if (avs_address_i == `OFF_REG_LO) begin
            rdata_d = fp_reg_q[regsel_q][31:0];
         end else if (avs_address_i == `OFF_REG_HI) begin
            rdata_d = fp_reg_q[regsel_q][63:32];
         end else if (avs_address_i == `OFF_REG_EXT) begin
            rdata_d = {16'h0, fp_reg_q[regsel_q][79:64]};
         end else begin
            rdata_d = 32'h0; // unmapped reads as zero
         end
      end
      if (bus_wr_take && avs_byteenable_i[0]) begin
         if (avs_address_i == `OFF_CTRL) begin
            ctrl_d = {4'h0, avs_writedata_i[3:1], 1'b0};
         end else if (avs_address_i == `OFF_REGSEL) begin
            regsel_d = avs_writedata_i[2:0];
         end
      end
   end

   assign avs_waitrequest_o = bus_req && !ack_q;
   assign avs_readdata_o = rdata_q;

   // state registers
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         for (int i = 0; i < `NUM_FP_REGS; i++) begin
            fp_reg_q[i] <= '0;
         end
         tag_q <= `TAG_RESET;
         status_q <= `STATUS_RESET;
         ctrl_q <= `CTRL_RESET;
         regsel_q <= 3'h0;
         ack_q <= 1'b0;
         rdata_q <= 32'h0;
         done_q <= 1'b0;
         fault_q <= FLT_NONE;
         prd_q <= '0;
         img_q <= '0;
         img_valid_q <= 1'b0;
      end else begin
         fp_reg_q <= fp_reg_d;
         tag_q <= tag_d;
         status_q <= status_d;
         ctrl_q <= ctrl_d;
         regsel_q <= regsel_d;
         ack_q <= ack_d;
         rdata_q <= rdata_d;
         done_q <= done_d;
         fault_q <= fault_d;
         prd_q <= prd_d;
         img_q <= img_d;
         img_valid_q <= img_valid_d;
      end
   end

   assign op_done_o = done_q;
   assign fault_o = fault_q;
   assign packed_rdata_o = prd_q;
   assign tag_img_o = img_q;
   assign tag_img_valid_o = img_valid_q;
   assign tag_word_o = tag_q;
   assign status_word_o = status_q;
   assign stack_top_o = status_q[`TOP_MSB:`TOP_LSB];

   // checks on the architectural side effects
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);

   property p_emulate_fault;
      is_packed && emulate_flag |=> op_done_o &&
         fault_o == FLT_INVALID_OPCODE;
   endproperty
   a_emulate_fault: assert property (p_emulate_fault)
      else $error("emulate flag did not give invalid opcode");

   property p_taskswitch_fault;
      is_packed && !emulate_flag && task_switched_flag |=>
         fault_o == FLT_COPROC_UNAVAIL && $stable(tag_word_o);
   endproperty
   a_taskswitch_fault: assert property (p_taskswitch_fault)
      else $error("task switch did not block packed op");

   property p_fill;
      packed_exec && op_kind_i == OP_PACKED_WRITE |=>
         fp_reg_q[$past(op_reg_i)] == {`UPPER_FILL, $past(op_data_i[63:0])};
   endproperty
   a_fill: assert property (p_fill)
      else $error("packed write did not fill upper bits");

   property p_fp_alias;
      // an idle cycle between keeps any other write out of the way
      op_valid_i && op_kind_i == OP_FP_WRITE ##1 !op_valid_i ##1
         packed_exec && op_kind_i == OP_PACKED_READ &&
         op_reg_i == $past(op_reg_i, 2) |=>
         packed_rdata_o == $past(op_data_i[63:0], 3);
   endproperty
   a_fp_alias: assert property (p_fp_alias)
      else $error("fp write not visible through packed register");

   property p_tags_valid;
      packed_exec && op_kind_i != OP_CLEAR_PACKED |=>
         tag_word_o == `TAGS_ALL_VALID;
   endproperty
   a_tags_valid: assert property (p_tags_valid)
      else $error("packed op left tags not valid");

   property p_tags_clear;
      packed_exec && op_kind_i == OP_CLEAR_PACKED |=>
         tag_word_o == `TAGS_ALL_EMPTY && fp_flat == $past(fp_flat);
   endproperty
   a_tags_clear: assert property (p_tags_clear)
      else $error("clear op did not empty tags");

   property p_top_keep;
      packed_exec |=> stack_top_o == 3'h0 &&
         (status_word_o & `STATUS_KEEP_MASK) ==
         ($past(status_word_o) & `STATUS_KEEP_MASK);
   endproperty
   a_top_keep: assert property (p_top_keep)
      else $error("packed op mishandled status word");

   property p_save;
      is_save |=> tag_img_valid_o && tag_img_o == $past(class_tags) &&
         tag_word_o == `TAGS_ALL_EMPTY;
   endproperty
   a_save: assert property (p_save)
      else $error("save did not image and empty tags");

   property p_err_first;
      is_packed && !emulate_flag && !task_switched_flag &&
         fp_err_pending_i |=> fault_o == FLT_FP_ERROR &&
         $stable(tag_word_o) && $stable(status_word_o);
   endproperty
   a_err_first: assert property (p_err_first)
      else $error("pending fp error not raised first");

   property p_bus_wait;
      bus_req && !ack_q |=> !avs_waitrequest_o;
   endproperty
   a_bus_wait: assert property (p_bus_wait)
      else $error("avalon answer later than one cycle");

   property p_fp_tag;
      op_valid_i && op_kind_i == OP_FP_WRITE |=>
         tag_word_o[2*$past(op_reg_i)+:2] ==
         ($past(op_tag_empty_i) ? `TAG_EMPTY : `TAG_VALID);
   endproperty
   a_fp_tag: assert property (p_fp_tag)
      else $error("fp write set the wrong tag");

   property p_restore_empty;
      is_restore |=> (tag_word_o & $past(img_empty)) == $past(img_empty);
   endproperty
   a_restore_empty: assert property (p_restore_empty)
      else $error("restore lost an empty tag");

   property p_read_keep;
      packed_exec && op_kind_i != OP_PACKED_WRITE |=>
         fp_flat == $past(fp_flat);
   endproperty
   a_read_keep: assert property (p_read_keep)
      else $error("packed op changed data registers");
endmodule : packed_simd_fp_alias_state

// ### logic/packed_simd_fp_alias_defs.svh
/*
 Constants for the packed-integer SIMD / floating-point alias state block:
 register offsets, field positions, tag codes and reset values.
 Assumes it is included by bare name from the package and the design file.
*/
// What this block does
// - emulate flag set: packed op gives invalid-opcode fault, any task flag
// - emulate clear: task flag clear executes, set gives coproc fault
// - eight 64-bit packed registers alias bits 0..63 of fp registers
// - packed-to-physical mapping is fixed, ignoring the stack top field
// - packed write overwrites bits 0..63 of the aliased fp register at once
// - fp write's low 64 bits read back through the aliased packed register
// - packed write forces bits 64..79 of the aliased fp register to ones
// - any packed op except clear sets all eight tags to 00B valid
// - clear-state op sets all tags to 11B empty, data unchanged
// - every packed op, clear included, loads stack top field with 000B
// - packed ops keep status bits 0..10, 14, 15 and other fp registers
// - packed contents and execution never depend on the live tag word
// - save and env-store write a tag image classified from contents
// - after save, env-store or extended save all live tags become 11B
// - ordinary fp ops update only the modified register's tag, 00B or 11B
// - restore: image 11B stays empty, others classified from register
// - restore and env-load read the tag image but never modify it
// - pending fp exception gives fp error fault before a packed op
`ifndef PACKED_SIMD_FP_ALIAS_DEFS_SVH
`define PACKED_SIMD_FP_ALIAS_DEFS_SVH

`define NUM_FP_REGS 8
`define FP_REG_W 80
`define PACKED_W 64
`define TAG_W 16
`define STATUS_W 16

// status word stack top field position
`define TOP_LSB 11
`define TOP_MSB 13
`define STATUS_KEEP_MASK 16'hc7ff

// tag codes
`define TAG_VALID 2'h0
`define TAG_ZERO 2'h1
`define TAG_SPECIAL 2'h2
`define TAG_EMPTY 2'h3
`define TAGS_ALL_VALID 16'h0000
`define TAGS_ALL_EMPTY 16'hffff
`define UPPER_FILL 16'hffff
`define EXP_ALL_ONES 15'h7fff

// reset values
`define TAG_RESET 16'hffff
`define STATUS_RESET 16'h0000
`define CTRL_RESET 8'h00

// register map, byte addresses (word index in address bits 4:2)
`define ADDR_W 5
`define OFF_CTRL 5'h00
`define OFF_STATE 5'h04
`define OFF_FAULT 5'h08
`define OFF_REGSEL 5'h0c
`define OFF_REG_LO 5'h10
`define OFF_REG_HI 5'h14
`define OFF_REG_EXT 5'h18

// control register bit positions
`define CTRL_MONITOR_BIT 1
`define CTRL_EMULATE_BIT 2
`define CTRL_TASKSW_BIT 3

`endif

// ### logic/packed_simd_pkg.sv
/*
 Types shared by the packed SIMD alias state block: instruction classes and
 fault outcomes. Assumes the defs header sits in the include path.
*/
package packed_simd_pkg;
   `include "packed_simd_fp_alias_defs.svh"

   // instruction class presented by the core's issue stage
   typedef enum logic [3:0] {
      OP_NONE = 4'h0,
      OP_PACKED_READ = 4'h1,
      OP_PACKED_WRITE = 4'h2,
      OP_CLEAR_PACKED = 4'h3,
      OP_FP_WRITE = 4'h4,
      OP_FP_SAVE = 4'h5,
      OP_FP_ENV_STORE = 4'h6,
      OP_EXT_SAVE = 4'h7,
      OP_FP_RESTORE = 4'h8,
      OP_FP_ENV_LOAD = 4'h9,
      OP_EXT_RESTORE = 4'ha
   } op_kind_t;

   // outcome of the instruction presented in the previous cycle, FLT_NONE after an idle cycle
   typedef enum logic [1:0] {
      FLT_NONE = 2'h0,
      FLT_INVALID_OPCODE = 2'h1,
      FLT_COPROC_UNAVAIL = 2'h2,
      FLT_FP_ERROR = 2'h3
   } fault_t;
endpackage : packed_simd_pkg

// ### sim/packed_simd_fp_alias_state_bench.sv
/*
 Self-checking bench for the packed SIMD alias state block: a model of the
 data registers, tag word and status word predicts every result.
 Assumes the package and the defs header are compiled before this file.
*/
`timescale 1ns/1ps
`include "packed_simd_fp_alias_defs.svh"
module packed_simd_fp_alias_state_bench;
   import packed_simd_pkg::*;
   logic clk_sys_i, rst_i, rd, wr, op_valid, op_te, op_swe, fp_err;
   logic done, img_valid, wait_o;
   logic [4:0] addr;
   logic [31:0] wdata, rdata, rv;
   logic [3:0] be;
   op_kind_t kind;
   fault_t fault;
   logic [2:0] op_reg, top;
   logic [79:0] op_data;
   logic [15:0] op_status, img_in, img, tagw, statw;
   logic [63:0] prd;
   logic [79:0] m_reg [8];
   logic [15:0] m_tag, m_stat;
   logic m_emul, m_tsw;
   int err_total, n_checks, seed;

   packed_simd_fp_alias_state packed_simd_fp_alias_state_inst (
      .clk_sys_i(clk_sys_i), .rst_i(rst_i), .avs_address_i(addr),
      .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
      .avs_byteenable_i(be), .avs_readdata_o(rdata),
      .avs_waitrequest_o(wait_o), .op_valid_i(op_valid), .op_kind_i(kind),
      .op_reg_i(op_reg), .op_data_i(op_data), .op_tag_empty_i(op_te),
      .op_status_i(op_status), .op_status_we_i(op_swe),
      .tag_img_in_i(img_in), .fp_err_pending_i(fp_err), .op_done_o(done),
      .fault_o(fault), .packed_rdata_o(prd), .tag_img_o(img),
      .tag_img_valid_o(img_valid), .tag_word_o(tagw),
      .status_word_o(statw), .stack_top_o(top));

   // free-running core clock, 4 ns period
   initial begin
      clk_sys_i = 1'b0;
      forever #2 clk_sys_i = ~clk_sys_i;
   end

   task automatic stop_test;
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : stop_test

   task automatic chk(string what, logic [79:0] exp, logic [79:0] got);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // one bus cycle; request held until waitrequest is seen low at an edge
   task automatic bus(logic w, logic [4:0] a, logic [31:0] d,
                      output logic [31:0] q);
      int i;
      @(posedge clk_sys_i);
      rd <= !w;
      wr <= w;
      addr <= a;
      wdata <= d;
      for (i = 0; i < 20; i++) begin
         @(posedge clk_sys_i);
         if (wait_o === 1'b0) break;
      end
      q = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
      if (i == 20) begin
         err_total++;
         stop_test();
      end
   endtask : bus

   // monitor flag always set before packed ops are used
   task automatic set_ctrl(logic emul, logic tsw);
      bus(1'b1, `OFF_CTRL, {28'h0, tsw, emul, 2'b10}, rv);
      m_emul = emul;
      m_tsw = tsw;
   endtask : set_ctrl

   // tag class from register contents
   function automatic logic [1:0] cls(logic [79:0] v);
      if (v[78:64] == 15'h0) return (v[63:0] == 64'h0) ? 2'h1 : 2'h2;
      if (v[78:64] == 15'h7fff || !v[63]) return 2'h2;
      return 2'h0;
   endfunction : cls

   function automatic logic [15:0] tags_from(logic [15:0] keep);
      logic [15:0] t;
      for (int n = 0; n < 8; n++) begin
         t[2*n +: 2] = (keep[2*n +: 2] == 2'h3) ? 2'h3 : cls(m_reg[n]);
      end
      return t;
   endfunction : tags_from

   // read one whole 80-bit register back over the bus
   task automatic peek(logic [2:0] r);
      bus(1'b1, `OFF_REGSEL, {29'h0, r}, rv);
      bus(1'b0, `OFF_REG_LO, 32'h0, rv);
      chk("reg low", m_reg[r][31:0], rv);
      bus(1'b0, `OFF_REG_HI, 32'h0, rv);
      chk("reg high", m_reg[r][63:32], rv);
      bus(1'b0, `OFF_REG_EXT, 32'h0, rv);
      chk("reg ext", m_reg[r][79:64], rv);
   endtask : peek

   // one instruction, model update, then every result output compared
   task automatic op(op_kind_t k, logic [2:0] r, logic [79:0] d, logic pe);
      logic pk, sv, te, swe;
      logic [15:0] st, im, ex_img;
      fault_t f;
      te = 1'($urandom);
      swe = 1'($urandom);
      st = 16'($urandom);
      im = 16'($urandom);
      ex_img = 16'h0;
      pk = k inside {OP_PACKED_READ, OP_PACKED_WRITE, OP_CLEAR_PACKED};
      sv = k inside {OP_FP_SAVE, OP_FP_ENV_STORE, OP_EXT_SAVE};
      f = !pk ? FLT_NONE : m_emul ? FLT_INVALID_OPCODE :
          m_tsw ? FLT_COPROC_UNAVAIL : pe ? FLT_FP_ERROR : FLT_NONE;
      @(posedge clk_sys_i);
      kind <= k;
      op_reg <= r;
      op_data <= d;
      op_te <= te;
      op_swe <= swe;
      op_status <= st;
      img_in <= im;
      fp_err <= pk & pe;
      op_valid <= 1'b1;
      if (pk && f == FLT_NONE) begin
         if (k == OP_PACKED_WRITE) m_reg[r] = {16'hffff, d[63:0]};
         m_tag = (k == OP_CLEAR_PACKED) ? 16'hffff : 16'h0000;
         m_stat[13:11] = 3'h0;
      end else if (k == OP_FP_WRITE) begin
         m_reg[r] = d;
         m_tag[2*r +: 2] = te ? 2'h3 : 2'h0;
         if (swe) m_stat = st;
      end else if (sv) begin
         ex_img = tags_from(m_tag);
         m_tag = 16'hffff;
      end else if (!pk && k != OP_NONE) begin
         m_tag = tags_from(im);
      end
      @(posedge clk_sys_i);
      op_valid <= 1'b0;
      #1;
      chk("done", 1'b1, done);
      chk("fault", f, fault);
      chk("tag word", m_tag, tagw);
      chk("status", m_stat, statw);
      chk("stack top", m_stat[13:11], top);
      chk("image valid", sv, img_valid);
      if (sv) chk("tag image", ex_img, img);
      if (k == OP_PACKED_READ && f == FLT_NONE)
         chk("packed read", m_reg[r][63:0], prd);
   endtask : op

   initial begin
      rst_i = 1'b1;
      {rd, wr, op_valid, op_te, op_swe, fp_err} = 6'h0;
      addr = 5'h0;
      wdata = 32'h0;
      be = 4'hf;
      kind = OP_NONE;
      op_reg = 3'h0;
      op_data = 80'h0;
      op_status = 16'h0;
      img_in = 16'h0;
      err_total = 0;
      n_checks = 0;
      seed = $urandom(32'habb23192);
      m_tag = 16'hffff;
      m_stat = 16'h0;
      m_emul = 1'b0;
      m_tsw = 1'b0;
      foreach (m_reg[n]) m_reg[n] = 80'h0;
      repeat (6) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      #1;
      chk("reset tags", 16'hffff, tagw);
      chk("reset status", 16'h0, statw);
      $display("test reset done");
      // every flag combination, with and without a pending fp exception
      for (int c = 0; c < 8; c++) begin
         set_ctrl(c[0], c[1]);
         op(OP_PACKED_WRITE, c[2:0], 80'({$urandom, $urandom, $urandom}),
            c[2]);
      end
      set_ctrl(1'b0, 1'b0);
      // a write without lane 0 enabled must leave the flags clear
      @(posedge clk_sys_i);
      be <= 4'h0;
      bus(1'b1, `OFF_CTRL, 32'h0000_000c, rv);
      be <= 4'hf;
      op(OP_PACKED_READ, 3'h5, 80'h0, 1'b0);
      bus(1'b0, 5'h1c, 32'h0, rv);
      chk("unmapped read", 32'h0, rv);
      $display("test gating done");
      // fp writes of zero, special, denormal and random values
      for (int n = 0; n < 8; n++) begin
         case (n % 4)
            0: op(OP_FP_WRITE, n[2:0], 80'h0, 1'b0);
            1: op(OP_FP_WRITE, n[2:0], {16'h7fff, 64'h8000_0000_0000_0001},
                  1'b0);
            2: op(OP_FP_WRITE, n[2:0], {16'h0, 64'h0123}, 1'b0);
            default: op(OP_FP_WRITE, n[2:0],
                        80'({$urandom, $urandom, $urandom}), 1'b0);
         endcase
         // read back after one idle cycle
         op(OP_PACKED_READ, n[2:0], 80'h0, 1'b0);
      end
      for (int n = 0; n < 8; n++) op(OP_PACKED_READ, n[2:0], 80'h0, 1'b0);
      for (int n = 0; n < 8; n++) peek(n[2:0]);
      $display("test aliasing done");
      // each save kind, then each restore kind
      for (int s = 0; s < 3; s++) begin
         op(OP_FP_WRITE, 3'($urandom), 80'({$urandom, $urandom, $urandom}),
            1'b0);
         op(op_kind_t'(5 + s), 3'h0, 80'h0, 1'b0);
      end
      for (int s = 0; s < 3; s++) op(op_kind_t'(8 + s), 3'h0, 80'h0, 1'b0);
      $display("test save restore done");
      // random mix of every instruction kind, one idle cycle after each
      for (int i = 0; i < 60; i++)
         op(op_kind_t'($urandom_range(1, 10)), 3'($urandom),
            80'({$urandom, $urandom, $urandom}), $urandom_range(0, 3) == 0);
      op(OP_CLEAR_PACKED, 3'h0, 80'h0, 1'b0);
      for (int n = 0; n < 8; n++) peek(n[2:0]);
      $display("test random mix done");
      stop_test();
   end
endmodule : packed_simd_fp_alias_state_bench
